/* File: flash_host_ctrl.sv */
// Host-side controller for a byte-wide parallel flash: reset, program,
// sector erase, status reads and sector protect selection.
// Assumes the flash pins are joined by the testbench; data pins are split
// into in/out/enable and the elevated reset voltage is an enable output.
//
// Summary of operation
// R1: Reset during an embedded operation: device ready within 20 us.
// R2: Reset while idle: device ready within 500 ns.
// R3: After reset release wait at least 50 ns before reading.
// R4: Hold reset low at least 20 us to reach standby.
// R5: Once ready/busy shows ready, next access may start at once.
// R6: Wait 90 ns after the last command write before trusting ready/busy.
// R7: Byte program nominally lasts 9 us.
// R8: Sector erase nominally lasts 0.7 s; timeout allows at least that.
// R9: Suspend toggle bit toggles only inside an erase-suspended sector.
// R10: Toggle bits advance per read, delimited by output or chip enable.
// R11: Op toggle bit valid at any address; polling needs a valid address.
// R12: Erase: last command cycle carries the sector address.
// R13: Protect: addr bit6 low, bit1 high, bit0 low; unprotect bit6 high.
// R14: Elevated reset voltage at least 4 us before any write command; a CTRL write that also turns vid on is not held.
// R15: While programming, polling bit reads inverted bit7 until done.
// R16: Embedded erase preprograms every byte to zero before erasing.
// R17: Ready/busy shows busy from command end until done or reset.
// R18: Hardware reset aborts an embedded operation, returns to array read.
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctrl #(
  parameter logic [31:0] PROG_TMO_CYC  = flash_host_pkg::PROG_TMO_DEF,
  parameter logic [31:0] ERASE_TMO_CYC = flash_host_pkg::ERASE_TMO_DEF,
  parameter logic [31:0] RST_LOW_CYCLES = flash_host_pkg::RST_LOW_CYC,
  parameter logic [31:0] VID_SETUP_CYCLES = flash_host_pkg::VID_SET_CYC
) (
  // Clock, reset, enable
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // Software register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // Flash pins
  output logic             o_flash_ce_n,
  output logic             o_flash_oe_n,
  output logic             o_flash_we_n,
  output logic             o_flash_rst_n,
  output logic             o_vid_en,
  output logic      [20:0] o_flash_addr,
  output logic      [7:0]  o_dq_out,
  output logic             o_dq_oe,
  input  wire logic [7:0]  i_dq_in,
  input  wire logic        i_ready_busy_n
);

  // ==========================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  // ==========================================================================
  logic [8:0] s1, s2, s3, filt;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1 <= 9'h000;
      s2 <= 9'h000;
      s3 <= 9'h000;
    end else if (i_clk_en) begin
      s1 <= {i_ready_busy_n, i_dq_in};
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_filt
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) filt[g] <= 1'b0;
        else if (i_clk_en && s2[g] == s3[g]) filt[g] <= s3[g];
      end
    end
  endgenerate
  wire       rb_ready = filt[8];
  wire [7:0] dq_now   = filt[7:0];

  // ==========================================================================
  // Registers and decode
  // ==========================================================================
  flash_host_pkg::state_e state, next_state;
  logic [2:0]  op, step;
  logic [20:0] target;
  logic [7:0]  wbyte, rd_byte;
  logic [31:0] cnt, tmo, vid_cnt;
  logic        done, timeout, refused, have_prev, prev_tog;
  logic        vid, rd_poll;

  wire sel_ctrl   = i_reg_addr == flash_host_pkg::REG_CTRL;
  wire sel_addr   = i_reg_addr == flash_host_pkg::REG_ADDR;
  wire sel_wdata  = i_reg_addr == flash_host_pkg::REG_WDATA;
  wire sel_status = i_reg_addr == flash_host_pkg::REG_STATUS;
  wire idle       = state == flash_host_pkg::S_IDLE;
  wire [2:0] req_op = i_reg_wdata[2:0];
  wire start      = i_reg_wr && sel_ctrl && req_op != flash_host_pkg::OP_NONE;
  wire vid_ok     = vid && vid_cnt == 32'h0;
  wire is_write_op = req_op == flash_host_pkg::OP_PROGRAM
                  || req_op == flash_host_pkg::OP_ERASE
                  || req_op == flash_host_pkg::OP_PROTECT
                  || req_op == flash_host_pkg::OP_UNPROT;
  // Reset is taken in any state so it can abort a running operation
  wire go_reset   = start && req_op == flash_host_pkg::OP_HWRST; // R18
  wire vid_block  = is_write_op && vid && !vid_ok; // R14
  wire go_other   = start && idle && !go_reset && !vid_block
                 && req_op <= flash_host_pkg::OP_UNPROT;
  wire refuse     = start && !go_reset && !go_other;
  wire vid_wr     = i_reg_wr && sel_ctrl && idle;

  // ==========================================================================
  // Command cycle selection
  // ==========================================================================
  wire is_prog  = op == flash_host_pkg::OP_PROGRAM;
  wire is_erase = op == flash_host_pkg::OP_ERASE;
  wire is_prot  = op == flash_host_pkg::OP_PROTECT
               || op == flash_host_pkg::OP_UNPROT;
  wire [2:0] last_step = is_erase ? flash_host_pkg::ERASE_LAST
                       : is_prog  ? flash_host_pkg::PROG_LAST : 3'h0;
  wire is_last  = step == last_step;
  wire unlock2  = step == 3'h1 || step == 3'h4;
  // Protect select drives bit6 by direction, bits 1:0 fixed
  wire [20:0] prot_addr = {target[20:7],
                           op == flash_host_pkg::OP_UNPROT,
                           target[5:2], flash_host_pkg::PROT_LOW_BITS}; // R13
  wire [20:0] last_addr = is_prot ? prot_addr : target; // R12
  wire [20:0] cyc_addr  = is_last ? last_addr
                        : unlock2 ? flash_host_pkg::UNLOCK2_ADDR
                        : flash_host_pkg::UNLOCK1_ADDR;
  wire [7:0] last_data  = is_erase ? flash_host_pkg::SECTOR_ERASE
                        : is_prot  ? flash_host_pkg::PROTECT_DATA : wbyte;
  wire [7:0] cyc_data   = is_last ? last_data
                        : unlock2 ? flash_host_pkg::UNLOCK2_DATA
                        : step == 3'h2 ? (is_erase ?
                            flash_host_pkg::ERASE_SETUP :
                            flash_host_pkg::PROGRAM_DATA)
                        : flash_host_pkg::UNLOCK1_DATA;

  // ==========================================================================
  // Completion test on each status read
  // ==========================================================================
  wire       cnt_zero = cnt == 32'h0;
  wire [31:0] tmo_lim = is_erase ? ERASE_TMO_CYC : PROG_TMO_CYC; // R7 R8
  wire       tog_same = have_prev
                     && prev_tog == dq_now[flash_host_pkg::OP_TOG_BIT]; // R11
  wire       poll_ok  = dq_now[flash_host_pkg::POLL_BIT]
                     == (is_prog ? wbyte[7] : 1'b1); // R15
  wire       op_done  = rb_ready && tog_same && poll_ok; // R5
  wire       tmo_hit  = tmo >= tmo_lim;
  wire       rd_end   = state == flash_host_pkg::S_RD && cnt_zero;

  always_comb begin
    next_state = state;
    unique case (state)
      flash_host_pkg::S_IDLE:
        if (go_other) begin
          next_state = (req_op == flash_host_pkg::OP_READ)
                     ? flash_host_pkg::S_RD : flash_host_pkg::S_WR_SET;
        end
      flash_host_pkg::S_RST_LOW:
        if (cnt_zero) next_state = flash_host_pkg::S_RST_REC;
      flash_host_pkg::S_RST_REC:
        if (cnt_zero) next_state = flash_host_pkg::S_IDLE;
      flash_host_pkg::S_WR_SET:
        next_state = flash_host_pkg::S_WR_LOW;
      flash_host_pkg::S_WR_LOW:
        if (cnt_zero) next_state = flash_host_pkg::S_WR_HIGH;
      flash_host_pkg::S_WR_HIGH:
        if (cnt_zero) begin
          next_state = !is_last ? flash_host_pkg::S_WR_SET
                     : is_prot ? flash_host_pkg::S_IDLE
                     : flash_host_pkg::S_BUSY_DLY; // R6 R17
        end
      flash_host_pkg::S_BUSY_DLY:
        if (cnt_zero) next_state = flash_host_pkg::S_RD;
      flash_host_pkg::S_RD:
        if (cnt_zero) begin
          next_state = (!rd_poll || op_done || tmo_hit)
                     ? flash_host_pkg::S_IDLE : flash_host_pkg::S_POLL_GAP;
        end
      flash_host_pkg::S_POLL_GAP:
        next_state = flash_host_pkg::S_RD; // R10
      default:
        next_state = flash_host_pkg::S_IDLE;
    endcase
    if (go_reset) next_state = flash_host_pkg::S_RST_LOW; // R18
  end

  wire entering = next_state != state;
  wire [31:0] dur =
      next_state == flash_host_pkg::S_RST_LOW  ? RST_LOW_CYCLES // R1 R2 R4
    : next_state == flash_host_pkg::S_RST_REC  ? flash_host_pkg::RST_REC_CYC
    : next_state == flash_host_pkg::S_WR_LOW   ? flash_host_pkg::WP_CYC
    : next_state == flash_host_pkg::S_WR_HIGH  ? flash_host_pkg::WPH_CYC
    : next_state == flash_host_pkg::S_BUSY_DLY ? flash_host_pkg::BUSY_DLY_CYC
    : next_state == flash_host_pkg::S_RD       ? flash_host_pkg::RD_CYC
    : 32'h1;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= flash_host_pkg::S_IDLE;
      cnt   <= 32'h0;
      step  <= 3'h0;
      op    <= flash_host_pkg::OP_NONE;
    end else if (i_clk_en) begin
      state <= next_state;
      cnt   <= entering ? dur - 32'h1 : (cnt_zero ? cnt : cnt - 32'h1);
      if (go_reset || go_other) op <= req_op;
      if (idle || go_reset) step <= 3'h0;
      else if (state == flash_host_pkg::S_WR_HIGH && cnt_zero)
        step <= step + 3'h1;
    end
  end

  // Status tracking; busy timeout counts from entry to the busy delay after the final command write
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tmo       <= 32'h0;
      have_prev <= 1'b0;
      prev_tog  <= 1'b0;
      rd_poll   <= 1'b0;
      rd_byte   <= 8'h00;
      done      <= 1'b0;
      timeout   <= 1'b0;
      refused   <= 1'b0;
    end else if (i_clk_en) begin
      if (go_other || go_reset) begin
        tmo       <= 32'h0;
        have_prev <= 1'b0;
        done      <= 1'b0;
        timeout   <= 1'b0;
        rd_poll   <= 1'b0;
      end else begin
        if (state == flash_host_pkg::S_BUSY_DLY) rd_poll <= 1'b1;
        if (rd_poll && !tmo_hit) tmo <= tmo + 32'h1;
        if (rd_end) begin
          rd_byte   <= dq_now;
          have_prev <= 1'b1;
          prev_tog  <= dq_now[flash_host_pkg::OP_TOG_BIT];
          if (rd_poll && !op_done && tmo_hit) timeout <= 1'b1; // R8
        end
        if (next_state == flash_host_pkg::S_IDLE && !idle) done <= 1'b1;
      end
      // A new refusal wins over a clear in the same cycle
      if (refuse) refused <= 1'b1;
      else if (i_reg_wr && sel_status
               && i_reg_wdata[flash_host_pkg::ST_REFUSED]) refused <= 1'b0;
    end
  end

  // Elevated reset voltage and its setup timer
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vid     <= 1'b0;
      vid_cnt <= 32'h0;
    end else if (i_clk_en) begin
      if (vid_wr) vid <= i_reg_wdata[flash_host_pkg::CTRL_VID_BIT];
      if (!vid) vid_cnt <= VID_SETUP_CYCLES; // R14
      else if (vid_cnt != 32'h0) vid_cnt <= vid_cnt - 32'h1;
    end
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      target <= 21'h000000;
      wbyte  <= 8'h00;
    end else if (i_clk_en) begin
      if (i_reg_wr && sel_addr && idle) target <= i_reg_wdata[20:0];
      if (i_reg_wr && sel_wdata && idle) wbyte <= i_reg_wdata[7:0];
    end
  end

  // Suspend toggle bit is only meaningful for an erase-suspended sector
  wire [31:0] status_word = {8'h00,
      6'h00, rd_byte[flash_host_pkg::SUSP_TOG_BIT],
      rd_byte[flash_host_pkg::OP_TOG_BIT], rd_byte,
      2'h0, vid_ok, rb_ready, refused, timeout, done, !idle}; // R9
  wire [31:0] rd_mux =
      sel_ctrl   ? {28'h0000000, vid, op} :
      sel_addr   ? {11'h000, target} :
      sel_wdata  ? {24'h000000, wbyte} :
      sel_status ? status_word : 32'h00000000;

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  wire wr_phase = state == flash_host_pkg::S_WR_SET
               || state == flash_host_pkg::S_WR_LOW
               || state == flash_host_pkg::S_WR_HIGH;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata   <= 32'h00000000;
      o_flash_ce_n  <= 1'b1;
      o_flash_oe_n  <= 1'b1;
      o_flash_we_n  <= 1'b1;
      o_flash_rst_n <= 1'b1;
      o_vid_en      <= 1'b0;
      o_flash_addr  <= 21'h000000;
      o_dq_out      <= 8'h00;
      o_dq_oe       <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rdata   <= i_reg_rd ? rd_mux : 32'h00000000;
      o_flash_ce_n  <= !(state == flash_host_pkg::S_WR_SET
                      || state == flash_host_pkg::S_WR_LOW
                      || state == flash_host_pkg::S_RD);
      o_flash_oe_n  <= state != flash_host_pkg::S_RD; // R10
      o_flash_we_n  <= state != flash_host_pkg::S_WR_LOW;
      o_flash_rst_n <= state != flash_host_pkg::S_RST_LOW; // R18
      o_vid_en      <= vid;
      o_flash_addr  <= wr_phase ? cyc_addr : target; // R11
      o_dq_out      <= cyc_data;
      o_dq_oe       <= wr_phase;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [31:0] low_len;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) low_len <= 32'h0;
    else if (i_clk_en) low_len <= o_flash_rst_n ? 32'h0 : low_len + 32'h1;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  reset_width_a: assert property ($rose(o_flash_rst_n) |-> // R4
    low_len >= RST_LOW_CYCLES) else $error("reset pulse too short");
  read_after_release_a: assert property ($rose(o_flash_rst_n) |-> // R3
    o_flash_oe_n [*7]) else $error("read too soon after reset release");
  busy_wait_a: assert property (i_clk_en && state == flash_host_pkg::S_WR_HIGH
    && cnt_zero && is_last && !is_prot && !go_reset |=> // R6
    state == flash_host_pkg::S_BUSY_DLY [*8]) else $error("busy not waited");
  ready_go_a: assert property (i_clk_en && rd_end && rd_poll && op_done // R5
    && !go_reset |=> idle) else $error("ready not acted on");
  erase_sector_a: assert property (state == flash_host_pkg::S_WR_LOW // R12
    && is_erase && is_last |-> o_flash_addr == target)
    else $error("erase address wrong");
  protect_addr_a: assert property (state == flash_host_pkg::S_WR_LOW // R13
    && is_prot |-> o_flash_addr[1:0] == 2'h2 && o_flash_addr[6] ==
    (op == flash_host_pkg::OP_UNPROT)) else $error("protect address wrong");
  vid_setup_a: assert property ($fell(o_flash_we_n) && vid |-> // R14
    vid_cnt == 32'h0) else $error("write before voltage setup");
  poll_gap_a: assert property (i_clk_en && state == // R10
    flash_host_pkg::S_POLL_GAP |=> o_flash_oe_n && o_flash_ce_n)
    else $error("status reads not delimited");
  reset_abort_a: assert property (i_clk_en && go_reset |=> // R18
    state == flash_host_pkg::S_RST_LOW ##1 !o_flash_rst_n)
    else $error("reset did not abort");
  prog_done_a: assert property ($rose(done) && is_prog && !timeout // R15
    |-> rd_byte[7] == wbyte[7]) else $error("program done on wrong data");

  prog_cov: cover property (idle ##1 state == flash_host_pkg::S_WR_SET
    ##[1:1000] $rose(done) && is_prog);
  erase_cov: cover property ($rose(done) && is_erase);
  reset_cov: cover property (go_reset && !idle);
  tmo_cov: cover property ($rose(timeout));

endmodule

`default_nettype wire

/* File: flash_host_pkg.sv */
// Constants for the parallel flash host controller: timing, register map,
// operation codes, command bytes and sequencer states.
// Assumes a 125 MHz system clock.
package flash_host_pkg;

  // ==========================================================================
  // Clock and pin times
  // ==========================================================================
  localparam int CLK_PERIOD_NS                 = 8;
  localparam int READY_EMBED_US                = 20;
  localparam int READY_IDLE_NS                 = 500;
  localparam int POST_RELEASE_READ_DELAY_NS    = 50;
  localparam int RESET_TO_STANDBY_TIME_US      = 20;
  localparam int BUSY_VALID_NS                 = 90;
  localparam int BYTE_PROGRAM_DURATION_US      = 9;
  localparam int SECTOR_ERASE_DURATION_MS      = 700;
  localparam int UNPROTECT_SETUP_TIME_US       = 4;
  localparam int WRITE_PULSE_NS                = 35;
  localparam int WRITE_HIGH_NS                 = 30;
  localparam int READ_ACCESS_NS                = 120;
  localparam int SYNC_LAT                      = 3;
  localparam int TIMEOUT_MULT                  = 4;

  // ==========================================================================
  // Cycle counts, least times rounded up
  // ==========================================================================
  localparam int RDY_EMB_C = (READY_EMBED_US * 1000 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int RDY_IDL_C = (READY_IDLE_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int STBY_C    = (RESET_TO_STANDBY_TIME_US * 1000
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_A_C   = (RDY_EMB_C > RDY_IDL_C) ? RDY_EMB_C : RDY_IDL_C;
  localparam logic [31:0] RST_LOW_CYC  = 32'((LOW_A_C > STBY_C) ? LOW_A_C
                                                               : STBY_C);
  localparam logic [31:0] RST_REC_CYC  = 32'((POST_RELEASE_READ_DELAY_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] BUSY_DLY_CYC = 32'((BUSY_VALID_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] VID_SET_CYC  = 32'((UNPROTECT_SETUP_TIME_US * 1000
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] WP_CYC       = 32'((WRITE_PULSE_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] WPH_CYC      = 32'((WRITE_HIGH_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] RD_CYC       = 32'((READ_ACCESS_NS
                                   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                   + SYNC_LAT);
  localparam int PROG_NOM_C  = BYTE_PROGRAM_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_NOM_C = SECTOR_ERASE_DURATION_MS * (1000000
                               / CLK_PERIOD_NS);
  localparam logic [31:0] PROG_TMO_DEF  = 32'(PROG_NOM_C * TIMEOUT_MULT);
  localparam logic [31:0] ERASE_TMO_DEF = 32'(ERASE_NOM_C * TIMEOUT_MULT);

  // ==========================================================================
  // Register map and fields
  // ==========================================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_VID_BIT  = 3;
  localparam int ST_ACTIVE     = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_TIMEOUT    = 2;
  localparam int ST_REFUSED    = 3;
  localparam int ST_RB         = 4;
  localparam int ST_VID_OK     = 5;
  localparam int ST_BYTE_LSB   = 8;
  localparam int ST_TOG_LSB    = 16;

  // ==========================================================================
  // Operations and command bytes
  // ==========================================================================
  localparam logic [2:0] OP_NONE    = 3'h0;
  localparam logic [2:0] OP_HWRST   = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_ERASE   = 3'h3;
  localparam logic [2:0] OP_READ    = 3'h4;
  localparam logic [2:0] OP_PROTECT = 3'h5;
  localparam logic [2:0] OP_UNPROT  = 3'h6;
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000AAA;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h000555;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  PROGRAM_DATA = 8'hA0;
  localparam logic [7:0]  ERASE_SETUP  = 8'h80;
  localparam logic [7:0]  SECTOR_ERASE = 8'h30;
  localparam logic [7:0]  PROTECT_DATA = 8'h60;
  localparam logic [2:0]  PROG_LAST    = 3'h3;
  localparam logic [2:0]  ERASE_LAST   = 3'h5;
  localparam int PROT_SEL_BIT  = 6;
  localparam logic [1:0] PROT_LOW_BITS = 2'h2;
  localparam int POLL_BIT      = 7;
  localparam int OP_TOG_BIT    = 6;
  localparam int SUSP_TOG_BIT  = 2;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_RST_LOW  = 4'h1,
    S_RST_REC  = 4'h2,
    S_WR_SET   = 4'h3,
    S_WR_LOW   = 4'h4,
    S_WR_HIGH  = 4'h5,
    S_RD       = 4'h6,
    S_BUSY_DLY = 4'h7,
    S_POLL_GAP = 4'h8
  } state_e;

endpackage

/* File: flash_dev_model.sv */
// Behavioural byte-wide flash device seen from its pins.
// Assumes registered host pin levels; one byte of array state only.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int PROG_NS  = 800,
  parameter int ERASE_NS = 1600
) (
  // Host pins
  input  wire logic       ce_n, oe_n, we_n, rst_n, slow,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            rb_n
);
  int         wcnt = 0, left = 0;
  logic       prog = 0, tog = 0;
  logic [7:0] pd = 8'hFF;
  initial begin rb_n = 1; dout = 8'h00; end
  // ==========================================
  // Command count; slow stretches busy 8x
  // Chip enable may rise with the write strobe: latch it on the fall
  logic       sel = 0;
  always @(negedge we_n) sel = !ce_n;
  always @(posedge we_n) if (sel && rst_n) begin
    wcnt++;
    if (wcnt == 3) prog = (din == 8'hA0);
    if (wcnt == 4 && prog) pd = din;
    if (din == 8'h60) wcnt = 0;
    if ((wcnt == 4 && prog) || wcnt == 6) begin
      rb_n = 0;
      left = (prog ? PROG_NS : ERASE_NS) * (slow ? 8 : 1);
      wcnt = 0;
    end
  end
  always #1 if (!rb_n) begin
    left--;
    if (left <= 0) begin rb_n = 1; if (!prog) pd = 8'hFF; end
  end
  always @(negedge rst_n) begin rb_n = 1; wcnt = 0; left = 0; end
  // Released bus shows the inverse; it is stale again while chip enable alone is low
  always @(ce_n, oe_n) begin
    if (!ce_n && !oe_n) begin
      if (!rb_n) tog = ~tog;
      dout = rb_n ? pd : {prog ? ~pd[7] : 1'b0, tog, 6'h00};
    end else dout = ~dout;
  end
endmodule
`default_nettype wire

/* File: flash_host_ctrl_test.sv */
// Self-checking bench for the flash host controller.
// Assumes flash_dev_model on the pins; short sim parameters.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin err_count++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module flash_host_ctrl_test;
  logic clk = 0, rst = 1, rw = 0, rr = 0, slow = 0, cen = 1;
  logic ce, oe, we, rn, vid, doe, rb;
  logic [7:0] ra = 0, din, dq;
  logic [31:0] wd = 0, rdat, q;
  logic [20:0] fa, la;
  int err_count = 0, tests_run = 0, lowc, wc;
  always #4 clk = ~clk;
  flash_host_ctrl #(.PROG_TMO_CYC(32'hC8), .ERASE_TMO_CYC(32'h190),
    .RST_LOW_CYCLES(32'h14), .VID_SETUP_CYCLES(32'hA)) u_flash_host_ctrl (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rdat),
    .o_flash_ce_n(ce), .o_flash_oe_n(oe), .o_flash_we_n(we),
    .o_flash_rst_n(rn), .o_vid_en(vid), .o_flash_addr(fa),
    .o_dq_out(dq), .o_dq_oe(doe), .i_dq_in(din), .i_ready_busy_n(rb));
  flash_dev_model u_flash_dev_model (.ce_n(ce), .oe_n(oe), .we_n(we),
    .rst_n(rn), .slow(slow), .din(dq), .dout(din), .rb_n(rb));
  always @(posedge we) if (!rst) begin
    wc++;
    la = fa;
    `CHK(doe, 1'b1)
  end
  always @(posedge clk) if (!rn) lowc++;
  // ==========================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); ra <= a; wd <= d; rw <= 1;
    @(posedge clk); rw <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk); ra <= a; rr <= 1;
    @(posedge clk); rr <= 0; #1 q = rdat;
  endtask
  // Bounded poll until done or timeout
  task automatic go(input logic [31:0] op);
    wc = 0; lowc = 0; q = 32'h1; wr(8'h00, op);
    for (int i = 0; i < 3000 && !(q[0] === 1'b0 && q[2:1] !== 2'b00); i++)
      rd(8'h0C);
    `CHK(q[0], 1'b0)
  endtask
  task automatic t_reset;
    go(32'h1); `CHK(lowc >= 20, 1'b1)
    `CHK(q[4:0], 5'h12)
  endtask
  task automatic t_prog;
    wr(8'h04, 32'h123); wr(8'h08, 32'h5A); go(32'h2);
    `CHK(q[15:0], 16'h5A12)
    `CHK(q[17:16], 2'h1)
    `CHK(la, 21'h123)
    `CHK(wc, 4)
  endtask
  task automatic t_erase;
    wr(8'h04, 32'h10000); go(32'h3); `CHK(wc, 6)
    `CHK(la, 21'h10000)
    `CHK(q[15:0], 16'hFF12)
    go(32'h4); `CHK(q[15:0], 16'hFF12)
  endtask
  task automatic t_prot;
    wr(8'h04, 32'h10047);
    for (int k = 0; k < 2; k++) begin
      go(32'h5 + k); `CHK(la, 21'h10006 | (k << 6))
    end
  endtask
  task automatic t_vid;
    @(posedge clk) cen <= 0;
    wr(8'h00, 32'h8); cen <= 1; rd(8'h00); `CHK(q[3], 1'b0)
    wr(8'h00, 32'h8); wr(8'h00, 32'hA); rd(8'h0C);
    `CHK({q[5], q[3], vid}, 3'h3)
    repeat (20) @(posedge clk);
    rd(8'h0C); `CHK(q[5], 1'b1)
    wr(8'h0C, 32'h8); wr(8'h00, 32'h0); rd(8'h10); `CHK(q, 32'h0)
  endtask
  task automatic t_tmo;
    slow <= 1; wr(8'h04, 32'h20000); go(32'h3);
    `CHK({q[2:0], rb}, 4'hC)
    slow <= 0; go(32'h1); `CHK({q[4:0], rb}, 6'h25)
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_reset; t_prog; t_erase; t_prot; t_vid; t_tmo; end_of_test;
  end
  initial begin #200000; err_count++; end_of_test; end
endmodule
`default_nettype wire
